/* bench/atcc_xtal_model.sv */
// Behavioural watch crystal on the oscillator pins of the timer
`timescale 1ns/1ps
module atcc_xtal_model #(
  parameter real HALF_NS = 21.7
) (
  // Oscillator enable from the timer
  input wire logic osc_run,
  // Crystal output to the timer
  output logic osc_in_pin
);
  // ----------------------------------------------------------------
  // Crystal behaviour
  // ----------------------------------------------------------------
  // Swings only while enabled, period far above four system clocks
  always begin
    // A stopped crystal settles low instead of keeping a half swing
    if (osc_run !== 1'b1) osc_in_pin = 1'b0;
    wait (osc_run === 1'b1);
    #(HALF_NS) osc_in_pin = ~osc_in_pin;
  end
endmodule : atcc_xtal_model

/* bench/tb.sv */
// Self-checking testbench for the asynchronous timer crossing block
`timescale 1ns/1ps
module tb;
  import atcc_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  atcc_req_t bus_req = '0;
  logic [DATA_W-1:0] bus_rdata;
  atcc_sleep_t sleep_mode = ATCC_ACTIVE;
  logic wake_req, osc_run, osc_in_pin, osc_out_pin_o, osc_out_pin_oe;
  logic osc_pins_detached, compare_output_pin, compare_irq, overflow_irq;
  int num_errors = 0;
  int compares = 0;
  int cyc = 0;
  logic [DATA_W-1:0] rv;
  // Clock and cycle count
  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 1;

  atcc_timer_cross atcc_timer_cross_i (
    .clk_sys(clk_sys), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .sleep_mode(sleep_mode), .wake_req(wake_req), .osc_run(osc_run),
    .osc_in_pin(osc_in_pin), .osc_out_pin_o(osc_out_pin_o),
    .osc_out_pin_oe(osc_out_pin_oe), .osc_pins_detached(osc_pins_detached),
    .compare_output_pin(compare_output_pin), .compare_irq(compare_irq),
    .overflow_irq(overflow_irq)
  );
  atcc_xtal_model atcc_xtal_model_i (.osc_run(osc_run), .osc_in_pin(osc_in_pin));

  // ----------------------------------------------------------------
  // Reporting and compare tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("Errors %0d, compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check8

  task automatic check_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: bit %b expected %b", $time, got, exp);
    end
  endtask : check_bit

  task automatic check_near(input logic [7:0] got, input int lo, input int hi);
    compares++;
    if (got < lo || got > hi || $isunknown(got)) begin
      num_errors++;
      $display("Error at %0t: value %h outside %0d..%0d", $time, got, lo, hi);
    end
  endtask : check_near

  // ----------------------------------------------------------------
  // Register bus tasks
  // ----------------------------------------------------------------
  task automatic bus_write(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys);
    bus_req <= '0;
  endtask : bus_write

  task automatic bus_read(input logic [ADDR_W-1:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_sys);
    bus_req <= '0;
    #1 d = bus_rdata;
  endtask : bus_read

  // Polls status until the given busy bits clear, bounded
  task automatic wait_idle(input logic [7:0] mask);
    logic [7:0] s;
    int n;
    n = 0;
    s = mask;
    while ((s & mask) != 8'h00 && n < 200) begin
      bus_read(OFS_STATUS, s);
      n++;
    end
    check8(s & mask, 8'h00);
  endtask : wait_idle

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    for (int a = 0; a < 8; a++) begin
      bus_read(a[ADDR_W-1:0], rv);
      check8(rv, 8'h00);
    end
    check_bit(osc_pins_detached, 1'b0);
    check_bit(osc_run, 1'b0);
  endtask : t_reset

  task automatic t_prescale();
    int div [8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
    for (int cs = 0; cs < 8; cs++) begin
      bus_write(OFS_CONTROL, 8'h00);
      bus_write(OFS_COUNT, 8'h00);
      bus_write(OFS_SPECIAL, 8'h01);
      bus_write(OFS_CONTROL, cs[7:0]);
      repeat ((cs == 0) ? 500 : 20 * div[cs]) @(posedge clk_sys);
      bus_read(OFS_COUNT, rv);
      if (cs == 0) check8(rv, 8'h00);
      else check_near(rv, 18, 21);
      bus_read(OFS_SPECIAL, rv);
      check8(rv, 8'h00);
    end
  endtask : t_prescale

  task automatic t_compare_sync();
    int n;
    bus_write(OFS_CONTROL, 8'h00);
    bus_write(OFS_COUNT, 8'h00);
    bus_write(OFS_COMPARE, 8'h30);
    bus_write(OFS_IRQ, 8'h0A);
    bus_write(OFS_CONTROL, 8'h11);
    n = 0;
    while (compare_irq !== 1'b1 && n < 200) begin
      @(posedge clk_sys);
      #1 n++;
    end
    check_bit(compare_irq, 1'b1);
    check_bit(compare_output_pin, 1'b1);
    bus_read(OFS_IRQ, rv);
    check_bit(rv[BIT_CMP_FLAG], 1'b1);
    // Clear-on-match mode pulls the pin back low
    bus_write(OFS_COUNT, 8'h20);
    bus_write(OFS_CONTROL, 8'h21);
    repeat (30) @(posedge clk_sys);
    check_bit(compare_output_pin, 1'b0);
    bus_write(OFS_CONTROL, 8'h00);
    bus_write(OFS_IRQ, 8'h08);
    bus_read(OFS_IRQ, rv);
    check8(rv, 8'h00);
  endtask : t_compare_sync

  task automatic t_async_write();
    int t0;
    bus_write(OFS_STATUS, 8'h08);
    #1 check_bit(osc_pins_detached, 1'b1);
    check_bit(osc_out_pin_o, 1'b0);
    check_bit(osc_out_pin_oe, 1'b0);
    check_bit(osc_run, 1'b1);
    bus_write(OFS_COMPARE, 8'h33);
    t0 = cyc;
    bus_write(OFS_COUNT, 8'h44);
    bus_read(OFS_STATUS, rv);
    check8(rv, 8'h0E);
    bus_write(OFS_STATUS, 8'h08);
    bus_read(OFS_STATUS, rv);
    check_bit(rv[BIT_CNT_BUSY], 1'b1);
    wait_idle(8'h07);
    check_bit(cyc - t0 >= 10, 1'b1);
    // Read copy only catches the commit on the next oscillator edge
    repeat (12) @(posedge clk_sys);
    bus_read(OFS_COUNT, rv);
    check8(rv, 8'h44);
    bus_read(OFS_COMPARE, rv);
    check8(rv, 8'h33);
    sleep_mode <= ATCC_POWER_DOWN;
    @(posedge clk_sys);
    #1 check_bit(osc_run, 1'b0);
    sleep_mode <= ATCC_STANDBY;
    @(posedge clk_sys);
    #1 check_bit(osc_run, 1'b0);
    sleep_mode <= ATCC_EXT_STANDBY;
    @(posedge clk_sys);
    #1 check_bit(osc_run, 1'b1);
    sleep_mode <= ATCC_ACTIVE;
    // Scaled settling pause after leaving deep sleep
    repeat (50) @(posedge clk_sys);
  endtask : t_async_write

  task automatic t_wake();
    int n;
    logic seen;
    bus_write(OFS_COUNT, 8'hFE);
    bus_write(OFS_CONTROL, 8'h01);
    wait_idle(8'h07);
    bus_write(OFS_IRQ, 8'h0D);
    sleep_mode <= ATCC_POWER_SAVE;
    n = 0;
    seen = 1'b0;
    while (!seen && n < 300) begin
      @(posedge clk_sys);
      #1 seen = (wake_req === 1'b1);
      n++;
    end
    check_bit(seen, 1'b1);
    sleep_mode <= ATCC_ACTIVE;
    check_bit(overflow_irq, 1'b1);
    bus_write(OFS_COMPARE, 8'h80);
    wait_idle(8'h02);
    bus_read(OFS_COUNT, rv);
    check_near(rv, 0, 3);
    bus_write(OFS_CONTROL, 8'h00);
  endtask : t_wake

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_prescale();
    t_compare_sync();
    t_async_write();
    t_wake();
    tally_and_finish();
  end

  initial begin
    #400_000;
    num_errors++;
    $display("Error at %0t: run did not complete", $time);
    tally_and_finish();
  end
endmodule : tb

/* common/atcc_pkg.sv */
// Constants and types for the asynchronous timer clock crossing
// What this block does
// RULE1: Software disables irqs before changing clock source
// RULE2: Processor clock above four times oscillator
// RULE3: Async writes commit after two oscillator edges
// RULE4: Each register has its own holding register
// RULE5: No rewrite while holding register is pending
// RULE6: Status shows per-register update-busy flags
// RULE7: Pending count or compare write suppresses match
// RULE8: Wait for busy clear before power-save
// RULE9: Interrupt logic rearms after one oscillator cycle
// RULE10: Oscillator runs except power-down and standby
// RULE11: Wait one second for oscillator start
// RULE12: Registers invalid after power-down or standby
// RULE13: Wake-up starts on next timer clock
// RULE14: Counter reads from copy refreshed per edge
// RULE15: Write, wait busy, then read counter
// RULE16: Flag sync takes three cycles plus one
// RULE17: Compare pin changes in timer domain
// RULE18: Source defaults to system clock, async bit
// RULE19: Async bit detaches both oscillator pins
// RULE20: Prescaler taps 8 to 1024, direct, stop
// RULE21: Prescaler reset bit resets the prescaler
// RULE22: Use a crystal, not external clock
// RULE23: Clock select zero stops, ascending taps
// RULE24: Busy set by write, cleared by transfer
// RULE25: Prescaler reset bit clears itself afterwards
package atcc_pkg;

  // ----------------------------------------------------------------
  // Register map and field layout
  // ----------------------------------------------------------------
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 3'h0;
  localparam logic [ADDR_W-1:0] OFS_COUNT = 3'h1;
  localparam logic [ADDR_W-1:0] OFS_COMPARE = 3'h2;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 3'h3;
  localparam logic [ADDR_W-1:0] OFS_SPECIAL = 3'h4;
  localparam logic [ADDR_W-1:0] OFS_IRQ = 3'h5;
  localparam int BIT_CTRL_BUSY = 0;
  localparam int BIT_CMP_BUSY = 1;
  localparam int BIT_CNT_BUSY = 2;
  localparam int BIT_ASYNC_SEL = 3;
  localparam int BIT_PSR = 0;
  localparam int BIT_OVF_EN = 0;
  localparam int BIT_CMP_EN = 1;
  localparam int BIT_OVF_FLAG = 2;
  localparam int BIT_CMP_FLAG = 3;
  localparam int CS_LSB = 0;
  localparam int COM_LSB = 4;
  localparam logic [DATA_W-1:0] RESET_VALUE = 8'h00;

  // ----------------------------------------------------------------
  // Counts
  // ----------------------------------------------------------------
  localparam int HOLD_COUNT = 3;
  localparam int COMMIT_EDGES = 2;
  localparam int FLAG_SYNC_CYCLES = 3;
  localparam int PRESCALE_W = 10;

  // Sleep modes reported by the power manager
  typedef enum logic [2:0] {
    ATCC_ACTIVE = 3'h0,
    ATCC_IDLE = 3'h1,
    ATCC_POWER_SAVE = 3'h3,
    ATCC_EXT_STANDBY = 3'h2,
    ATCC_POWER_DOWN = 3'h6,
    ATCC_STANDBY = 3'h7
  } atcc_sleep_t;

  // Register bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } atcc_req_t;

endpackage : atcc_pkg

/* logic/atcc_hold_reg.sv */
// Holding register with update-busy flag for one asynchronous register
`timescale 1ns/1ps
module atcc_hold_reg #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Processor side
  input wire logic load,
  input wire logic [WIDTH-1:0] load_data,
  input wire logic async_mode,
  // Timer side
  input wire logic osc_rise,
  output logic busy,
  output logic commit,
  output logic [WIDTH-1:0] hold_data
);
  import atcc_pkg::*;

  logic busy_ff;
  logic commit_ff;
  logic [1:0] edge_cnt_ff;
  logic [WIDTH-1:0] data_ff;

  initial begin
    if (WIDTH < 1) $error("atcc_hold_reg: WIDTH must be positive");
  end

  // Capture written value
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      data_ff <= '0;
    end else if (load) begin
      data_ff <= load_data;
    end
  end

  // Busy and commit after two oscillator edges in async mode, commit on the next cycle otherwise
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      busy_ff <= 1'b0;
      commit_ff <= 1'b0;
      edge_cnt_ff <= 2'h0;
    end else begin
      commit_ff <= 1'b0;
      if (load && async_mode) begin
        busy_ff <= 1'b1; // RULE24
        edge_cnt_ff <= 2'h0;
      end else if (load) begin
        commit_ff <= 1'b1;
      end else if (busy_ff && osc_rise) begin
        if (edge_cnt_ff == 2'(COMMIT_EDGES - 1)) begin
          commit_ff <= 1'b1; // RULE3
          busy_ff <= 1'b0;
        end else begin
          edge_cnt_ff <= edge_cnt_ff + 2'h1;
        end
      end
    end
  end

  // Busy holds until the destination has taken the value
  assign busy = busy_ff | (commit_ff & async_mode); // RULE6
  assign commit = commit_ff;
  assign hold_data = data_ff;

  chk_commit_on_edge: assert property (@(posedge clk_sys) disable iff (rst) // RULE3
    (commit_ff && !$past(load)) |-> $past(osc_rise))
    else $error("async commit without oscillator edge");

endmodule : atcc_hold_reg

/* logic/atcc_timer_cross.sv */
// Clock source, prescaler and crossing logic of the asynchronous timer
//
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module atcc_timer_cross (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Register bus
  input wire atcc_pkg::atcc_req_t bus_req,
  output logic [atcc_pkg::DATA_W-1:0] bus_rdata,
  // Power manager
  input wire atcc_pkg::atcc_sleep_t sleep_mode,
  output logic wake_req,
  output logic osc_run,
  // Oscillator pins
  input wire logic osc_in_pin,
  output logic osc_out_pin_o,
  output logic osc_out_pin_oe,
  output logic osc_pins_detached,
  // Compare output and interrupt requests
  output logic compare_output_pin,
  output logic compare_irq,
  output logic overflow_irq
);
  import atcc_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Prescaler tap for a clock select code
  function automatic logic tap_hit(input logic [2:0] cs, input logic [PRESCALE_W-1:0] pre);
    logic hit;
    hit = 1'b0;
    case (cs)
      3'd1: hit = 1'b1;
      3'd2: hit = &pre[2:0];
      3'd3: hit = &pre[4:0];
      3'd4: hit = &pre[5:0];
      3'd5: hit = &pre[6:0];
      3'd6: hit = &pre[7:0];
      3'd7: hit = &pre[9:0];
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction : tap_hit

  // Write strobe for one register
  function automatic logic wr_at(input atcc_req_t r, input logic [ADDR_W-1:0] ofs);
    return r.wr && (r.addr == ofs);
  endfunction : wr_at

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic osc_meta_ff;
  logic osc_sync_ff;
  logic osc_prev_ff;
  logic osc_rise;
  logic async_sel_ff;
  logic psr_ff;
  logic [PRESCALE_W-1:0] prescale_ff;
  logic src_tick;
  logic count_tick;
  logic [DATA_W-1:0] count_ff;
  logic [DATA_W-1:0] compare_ff;
  logic [DATA_W-1:0] control_ff;
  logic [DATA_W-1:0] count_copy_ff;
  logic [HOLD_COUNT-1:0] busy;
  logic [HOLD_COUNT-1:0] commit;
  logic [HOLD_COUNT-1:0] load;
  logic [DATA_W-1:0] hold_data [HOLD_COUNT];
  logic cmp_event;
  logic ovf_event;
  logic [FLAG_SYNC_CYCLES-2:0] cmp_sr_ff;
  logic [FLAG_SYNC_CYCLES-2:0] ovf_sr_ff;
  logic cmp_flag_ff;
  logic ovf_flag_ff;
  logic cmp_en_ff;
  logic ovf_en_ff;
  logic oc_ff;
  logic wake_pend_ff;
  logic wake_req_ff;
  logic rearm_ff;
  logic light_sleep;
  logic [DATA_W-1:0] rdata_ff;
  logic [DATA_W-1:0] nxt_rdata;

  // ----------------------------------------------------------------
  // Oscillator pin and clock source
  // ----------------------------------------------------------------
  // Two-flop synchroniser, then edge detect on the second stage
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      osc_meta_ff <= 1'b0;
      osc_sync_ff <= 1'b0;
      osc_prev_ff <= 1'b0;
    end else begin
      osc_meta_ff <= osc_in_pin;
      osc_sync_ff <= osc_meta_ff;
      osc_prev_ff <= osc_sync_ff;
    end
  end

  // Rising oscillator edge only counts in async mode
  assign osc_rise = async_sel_ff & osc_sync_ff & ~osc_prev_ff;

  // Source is the system clock unless async is selected
  assign src_tick = async_sel_ff ? osc_rise : 1'b1; // RULE18

  // Pins leave the port while async is selected
  assign osc_pins_detached = async_sel_ff; // RULE19
  assign osc_out_pin_o = 1'b0;
  assign osc_out_pin_oe = 1'b0;

  // Oscillator runs only with async selected, and stops in power-down and standby
  assign osc_run = async_sel_ff && (sleep_mode != ATCC_POWER_DOWN)
                   && (sleep_mode != ATCC_STANDBY); // RULE10

  // Async select bit
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      async_sel_ff <= 1'b0; // RULE18
    end else if (wr_at(bus_req, OFS_STATUS)) begin
      async_sel_ff <= bus_req.wdata[BIT_ASYNC_SEL];
    end
  end

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  // Reset bit clears once the reset has been applied
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      psr_ff <= 1'b0;
    end else if (wr_at(bus_req, OFS_SPECIAL) && bus_req.wdata[BIT_PSR]) begin
      psr_ff <= 1'b1;
    end else begin
      psr_ff <= 1'b0; // RULE25
    end
  end

  // Free-running divider on the source clock
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prescale_ff <= '0;
    end else if (psr_ff) begin
      prescale_ff <= '0; // RULE21
    end else if (src_tick) begin
      prescale_ff <= prescale_ff + PRESCALE_W'(1);
    end
  end

  // Counting clock from the selected tap
  assign count_tick = src_tick
    && tap_hit(control_ff[CS_LSB +: 3], prescale_ff); // RULE20 RULE23

  // ----------------------------------------------------------------
  // Holding registers
  // ----------------------------------------------------------------
  assign load[0] = wr_at(bus_req, OFS_CONTROL);
  assign load[1] = wr_at(bus_req, OFS_COMPARE);
  assign load[2] = wr_at(bus_req, OFS_COUNT);

  // One independent holding register per destination
  for (genvar i = 0; i < HOLD_COUNT; i++) begin : g_hold
    atcc_hold_reg #(.WIDTH(DATA_W)) u_hold ( // RULE4
      .clk_sys(clk_sys),
      .rst(rst),
      .load(load[i]),
      .load_data(bus_req.wdata),
      .async_mode(async_sel_ff),
      .osc_rise(osc_rise),
      .busy(busy[i]),
      .commit(commit[i]),
      .hold_data(hold_data[i])
    );
  end

  // Control and compare destinations
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      control_ff <= RESET_VALUE;
      compare_ff <= RESET_VALUE;
    end else begin
      if (commit[0]) begin
        control_ff <= {1'b0, hold_data[0][DATA_W-2:0]}; // RULE3
      end
      if (commit[1]) begin
        compare_ff <= hold_data[1]; // RULE3
      end
    end
  end

  // Counter, a committed write wins over counting
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      count_ff <= RESET_VALUE;
    end else if (commit[2]) begin
      count_ff <= hold_data[2]; // RULE3
    end else if (count_tick) begin
      count_ff <= count_ff + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Timer-domain events and compare pin
  // ----------------------------------------------------------------
  // Match is blocked while compare or count writes are pending
  assign cmp_event = count_tick && (count_ff == compare_ff)
                     && !busy[1] && !busy[2]; // RULE7
  assign ovf_event = count_tick && (count_ff == 8'hFF);

  // Compare pin acts on the timer tick, not resynchronised
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      oc_ff <= 1'b0;
    end else if (cmp_event) begin
      unique case (control_ff[COM_LSB +: 2]) // RULE17
        2'b01: oc_ff <= ~oc_ff;
        2'b10: oc_ff <= 1'b0;
        2'b11: oc_ff <= 1'b1;
        2'b00: oc_ff <= oc_ff;
      endcase
    end
  end

  assign compare_output_pin = oc_ff;

  // ----------------------------------------------------------------
  // Counter read copy
  // ----------------------------------------------------------------
  // Refreshed on each oscillator edge in async mode, every cycle otherwise; stale until then after wake
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      count_copy_ff <= RESET_VALUE;
    end else if (!async_sel_ff || osc_rise) begin
      count_copy_ff <= count_ff; // RULE14
    end
  end

  // ----------------------------------------------------------------
  // Interrupt flags
  // ----------------------------------------------------------------
  // Flag delay stages, bypassed in synchronous mode
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cmp_sr_ff <= '0;
      ovf_sr_ff <= '0;
    end else begin
      cmp_sr_ff <= {cmp_sr_ff[FLAG_SYNC_CYCLES-3:0], cmp_event}; // RULE16
      ovf_sr_ff <= {ovf_sr_ff[FLAG_SYNC_CYCLES-3:0], ovf_event}; // RULE16
    end
  end

  // Sticky flags, a set beats a clear in the same cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cmp_flag_ff <= 1'b0;
      ovf_flag_ff <= 1'b0;
    end else begin
      if (async_sel_ff ? cmp_sr_ff[FLAG_SYNC_CYCLES-2] : cmp_event) begin
        cmp_flag_ff <= 1'b1;
      end else if (wr_at(bus_req, OFS_IRQ) && bus_req.wdata[BIT_CMP_FLAG]) begin
        cmp_flag_ff <= 1'b0;
      end
      if (async_sel_ff ? ovf_sr_ff[FLAG_SYNC_CYCLES-2] : ovf_event) begin
        ovf_flag_ff <= 1'b1;
      end else if (wr_at(bus_req, OFS_IRQ) && bus_req.wdata[BIT_OVF_FLAG]) begin
        ovf_flag_ff <= 1'b0;
      end
    end
  end

  // Interrupt enables
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cmp_en_ff <= 1'b0;
      ovf_en_ff <= 1'b0;
    end else if (wr_at(bus_req, OFS_IRQ)) begin
      cmp_en_ff <= bus_req.wdata[BIT_CMP_EN];
      ovf_en_ff <= bus_req.wdata[BIT_OVF_EN];
    end
  end

  assign compare_irq = cmp_flag_ff & cmp_en_ff;
  assign overflow_irq = ovf_flag_ff & ovf_en_ff;

  // ----------------------------------------------------------------
  // Wake-up from light sleep
  // ----------------------------------------------------------------
  assign light_sleep = (sleep_mode == ATCC_POWER_SAVE) || (sleep_mode == ATCC_EXT_STANDBY);

  // Wake starts on the next oscillator edge, then rearms an edge later
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wake_pend_ff <= 1'b0;
      wake_req_ff <= 1'b0;
      rearm_ff <= 1'b1;
    end else begin
      wake_req_ff <= 1'b0;
      if (light_sleep && async_sel_ff && rearm_ff
          && ((cmp_event && cmp_en_ff) || (ovf_event && ovf_en_ff))) begin
        wake_pend_ff <= 1'b1;
      end
      if (wake_pend_ff && osc_rise) begin
        wake_req_ff <= 1'b1; // RULE13
        wake_pend_ff <= 1'b0;
        rearm_ff <= 1'b0;
      end else if (!rearm_ff && osc_rise) begin
        rearm_ff <= 1'b1; // RULE9
      end
    end
  end

  assign wake_req = wake_req_ff;

  // ----------------------------------------------------------------
  // Register read
  // ----------------------------------------------------------------
  // Read mux, unmapped addresses return zero
  always_comb begin
    nxt_rdata = '0;
    case (bus_req.addr)
      OFS_CONTROL: nxt_rdata = control_ff;
      OFS_COUNT: nxt_rdata = count_copy_ff; // RULE14
      OFS_COMPARE: nxt_rdata = compare_ff;
      OFS_STATUS: nxt_rdata = {4'h0, async_sel_ff, busy[2], busy[1], busy[0]}; // RULE6
      OFS_SPECIAL: nxt_rdata = {7'h00, psr_ff};
      OFS_IRQ: nxt_rdata = {4'h0, cmp_flag_ff, ovf_flag_ff, cmp_en_ff, ovf_en_ff};
      default: nxt_rdata = '0;
    endcase
  end

  // Read data one cycle after the strobe, only then
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= bus_req.rd ? nxt_rdata : '0;
    end
  end

  assign bus_rdata = rdata_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  chk_busy_on_write: assert property ( // RULE24
    (async_sel_ff && wr_at(bus_req, OFS_COUNT)) |=> busy[2])
    else $error("count busy not set by async write");

  chk_no_early_commit: assert property ( // RULE3
    (async_sel_ff && wr_at(bus_req, OFS_COMPARE) && !osc_rise) |=> !commit[1])
    else $error("compare committed before oscillator edges");

  chk_match_blocked: assert property ( // RULE7
    (busy[1] || busy[2]) |=> $stable(oc_ff))
    else $error("compare pin moved while write pending");

  chk_copy_stable: assert property ( // RULE14
    (async_sel_ff && $past(async_sel_ff) && !$past(osc_rise)) |-> $stable(count_copy_ff))
    else $error("count copy changed without oscillator edge");

  chk_flag_delay: assert property ( // RULE16
    (async_sel_ff && ovf_event && !wr_at(bus_req, OFS_STATUS)) |-> ##3 ovf_flag_ff)
    else $error("overflow flag not set three cycles after event");

  chk_osc_stops: assert property ( // RULE10
    (sleep_mode == ATCC_POWER_DOWN || sleep_mode == ATCC_STANDBY) |-> !osc_run)
    else $error("oscillator running in deep sleep");

  chk_pins_detach: assert property ( // RULE19
    (wr_at(bus_req, OFS_STATUS) && bus_req.wdata[BIT_ASYNC_SEL]) |=> osc_pins_detached)
    else $error("pins not detached after async select");

  chk_psr_clears: assert property ( // RULE21 RULE25
    psr_ff |=> (prescale_ff == '0) && !(psr_ff && !$past(wr_at(bus_req, OFS_SPECIAL))))
    else $error("prescaler reset not applied or not cleared");

  chk_wake_on_edge: assert property ( // RULE13
    wake_req |-> $past(osc_rise) && $past(wake_pend_ff))
    else $error("wake request not on oscillator edge");

  chk_stop_select: assert property ( // RULE23
    (control_ff[CS_LSB +: 3] == 3'h0) |-> !count_tick)
    else $error("counter ticking with clock stopped");

endmodule : atcc_timer_cross
